// >>> hw/arg_top.v
`timescale 1ns/1ns
`include "arg_consts.vh"
module arg_top (
  input  wire         clk,
  input  wire         nrst,
  input  wire         ce,
  input  wire         reg_wr,
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  output reg  [7:0]   reg_rdata,
  input  wire         fm_ident_switch_enable,
  input  wire [1:0]   fm_sound_mode,
  input  wire [1:0]   nicam_sound_mode,
  input  wire         auto_mute,
  input  wire [1:0]   channel2_mode,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [15:0]  fm_l,
  input  wire [15:0]  fm_r,
  input  wire [15:0]  nic_l,
  input  wire [15:0]  nic_r,
  input  wire [15:0]  nic_m1,
  input  wire [15:0]  nic_m2,
  output wire         ser_valid,
  input  wire         ser_ready,
  output wire [31:0]  ser_data,
  output reg          dac_valid,
  output reg  [15:0]  dac_data,
  output reg  [1:0]   dac_level_sel,
  output wire [63:0]  demod_settings
);

  reg  [7:0]  out_select_r;
  reg  [7:0]  out_gain_r;
  reg  [7:0]  dac_select_r;
  reg  [7:0]  preset_r;
  reg  [7:0]  demod_r [0:7];
  reg  [15:0] s1_l_r;
  reg  [15:0] s1_r_r;
  reg         s1_vld_r;
  reg  [15:0] mx_l;
  reg  [15:0] mx_r;
  reg  [15:0] src_l;
  reg  [15:0] src_r;
  reg  [15:0] dac_nxt;
  reg  [1:0]  lvl_nxt;
  reg  [1:0]  snd_mode;
  wire        auto_on;
  wire [2:0]  mtx_mode;
  wire [1:0]  src_sel;
  wire [1:0]  dac_src;
  wire [1:0]  dac_gain_code;
  wire        fifo_rdy;
  wire        accept;
  wire        std_valid;
  wire        preset_wr;
  wire [15:0] g_l;
  wire [15:0] g_r;
  wire [15:0] gain_coef;
  integer     i;
  genvar      gi;

  // ==========================================================
  // helpers
  function [15:0] avg;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s   = {a[15], a} + {b[15], b};
      avg = s[16:1];
    end
  endfunction

  function [15:0] scale;
    input [15:0] x;
    input [15:0] c;
    reg   [32:0] p;
    reg   [32:0] q;
    begin
      p = $signed(x) * $signed({1'b0, c});
      q = $signed(p) >>> `ARG_GAIN_SHIFT;
      if ($signed(q) > $signed(33'h00007FFF)) begin
        scale = 16'h7FFF;
      end else if ($signed(q) < $signed(33'h1FFFF8000)) begin
        scale = 16'h8000;
      end else begin
        scale = q[15:0];
      end
    end
  endfunction

  function [15:0] ser_coef;
    input [4:0] g;
    begin
      case (g)
        5'h00: ser_coef = `ARG_UNITY;
        5'h01: ser_coef = 16'h11F4;
        5'h02: ser_coef = 16'h1425;
        5'h03: ser_coef = 16'h169A;
        5'h04: ser_coef = 16'h195C;
        5'h05: ser_coef = 16'h1C74;
        5'h06: ser_coef = 16'h1FED;
        5'h07: ser_coef = 16'h23D2;
        5'h08: ser_coef = 16'h2831;
        5'h09: ser_coef = 16'h2D19;
        5'h0A: ser_coef = 16'h3299;
        5'h0B: ser_coef = 16'h38C5;
        5'h0C: ser_coef = 16'h3FB2;
        5'h0D: ser_coef = 16'h4778;
        5'h0E: ser_coef = 16'h5031;
        5'h0F: ser_coef = 16'h59F9;
        5'h1E: ser_coef = 16'h0E43;
        5'h1D: ser_coef = 16'h0CB6;
        5'h1C: ser_coef = 16'h0B54;
        5'h1B: ser_coef = 16'h0A18;
        5'h1A: ser_coef = 16'h08FF;
        5'h19: ser_coef = 16'h0805;
        5'h18: ser_coef = 16'h0726;
        5'h17: ser_coef = 16'h065F;
        5'h16: ser_coef = 16'h05AD;
        5'h15: ser_coef = 16'h050F;
        5'h14: ser_coef = 16'h0482;
        5'h13: ser_coef = 16'h0405;
        5'h12: ser_coef = 16'h0395;
        5'h11: ser_coef = 16'h0331;
        5'h10: ser_coef = 16'h02D8;
        default: ser_coef = `ARG_UNITY;
      endcase
    end
  endfunction

  function [15:0] dac_coef;
    input [1:0] g;
    begin
      case (g)
        2'h0:    dac_coef = `ARG_UNITY;
        2'h1:    dac_coef = 16'h169A;
        2'h2:    dac_coef = 16'h1FED;
        default: dac_coef = 16'h2D19;
      endcase
    end
  endfunction

  function [7:0] std_byte;
    input [3:0] code;
    input [2:0] idx;
    begin
      std_byte = {code, 1'b0, idx};
    end
  endfunction

  // ==========================================================
  // register fields
  assign auto_on       = out_select_r[7] && fm_ident_switch_enable;
  assign mtx_mode      = out_select_r[6:4];
  assign src_sel       = out_select_r[1:0];
  assign dac_src       = dac_select_r[1:0];
  assign dac_gain_code = {dac_select_r[7], dac_select_r[3]};
  assign std_valid     = (reg_wdata[3:0] <= `ARG_STD_LAST_A2N) ||
                         (reg_wdata[3:0] == `ARG_STD_SAT);
  assign preset_wr     = ce && reg_wr && (reg_addr == `ARG_SA_PRESET);

  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_demod
      assign demod_settings[gi*8 +: 8] = demod_r[gi];
    end
  endgenerate

  // ==========================================================
  // register writes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_select_r <= `ARG_RST_BYTE;
      out_gain_r   <= `ARG_RST_BYTE;
      dac_select_r <= `ARG_RST_BYTE;
      preset_r     <= `ARG_RST_BYTE;
      for (i = 0; i < 8; i = i + 1) begin
        demod_r[i] <= `ARG_RST_BYTE;
      end
    end else if (ce && reg_wr) begin
      if (reg_addr == `ARG_SA_OUT_SELECT) begin
        out_select_r <= reg_wdata & `ARG_SEL_MASK;
      end
      if (reg_addr == `ARG_SA_OUT_GAIN) begin
        out_gain_r <= reg_wdata;
      end
      if (reg_addr == `ARG_SA_DAC_SELECT) begin
        dac_select_r <= reg_wdata;
      end
      if (reg_addr >= `ARG_SA_DEMOD_FIRST && reg_addr <= `ARG_SA_DEMOD_LAST) begin
        demod_r[reg_addr[2:0] - 3'h3] <= reg_wdata;
      end
      if (preset_wr) begin
        preset_r <= reg_wdata;
        if (std_valid) begin
          for (i = 0; i < 8; i = i + 1) begin
            demod_r[i] <= std_byte(reg_wdata[3:0], i[2:0]);
          end
        end
        demod_r[6][7:4] <= reg_wdata[7:4];
      end
    end
  end

  // ==========================================================
  // register reads
  always @* begin
    reg_rdata = `ARG_RD_NONE;
    case (reg_addr)
      `ARG_SA_OUT_SELECT: reg_rdata = out_select_r;
      `ARG_SA_OUT_GAIN:   reg_rdata = out_gain_r;
      `ARG_SA_DAC_SELECT: reg_rdata = dac_select_r;
      `ARG_SA_PRESET:     reg_rdata = preset_r;
      default: begin
        if (reg_addr >= `ARG_SA_DEMOD_FIRST && reg_addr <= `ARG_SA_DEMOD_LAST) begin
          reg_rdata = demod_r[reg_addr[2:0] - 3'h3];
        end
      end
    endcase
  end

  // ==========================================================
  // serial output source and matrix
  always @* begin
    case (src_sel)
      2'h0: begin
        src_l = fm_l;
        src_r = fm_r;
      end
      2'h1: begin
        src_l = nic_l;
        src_r = nic_r;
      end
      2'h2: begin
        src_l = fm_l;
        src_r = nic_m1;
      end
      default: begin
        src_l = fm_l;
        src_r = nic_m2;
      end
    endcase
    snd_mode = src_sel[0] ? nicam_sound_mode : fm_sound_mode;
    mx_l = src_l;
    mx_r = src_r;
    if (auto_on && !src_sel[1] && !mtx_mode[2] && !(mtx_mode[1] && mtx_mode[0])) begin
      if (auto_mute && channel2_mode == `ARG_CH2_MUTE_MODE) begin
        mx_l = fm_l;
        mx_r = fm_l;
      end else if (snd_mode == `ARG_MODE_DUAL) begin
        mx_l = mtx_mode[1] ? src_r : src_l;
        mx_r = mtx_mode[1] ? src_r : src_l;
      end else if (snd_mode != `ARG_MODE_STEREO) begin
        mx_l = src_l;
        mx_r = src_l;
      end
    end else begin
      case (mtx_mode)
        3'h1: mx_r = src_l;
        3'h2: mx_l = src_r;
        3'h3: begin
          mx_l = src_r;
          mx_r = src_l;
        end
        3'h4: begin
          mx_l = avg(src_l, src_r);
          mx_r = avg(src_l, src_r);
        end
        default: begin
          mx_l = src_l;
          mx_r = src_r;
        end
      endcase
    end
  end

  // ==========================================================
  // mono DAC source, always automatic
  always @* begin
    dac_nxt = fm_l;
    lvl_nxt = `ARG_LVL_CH1;
    case (dac_src)
      2'h0, 2'h1: begin
        if (fm_sound_mode == `ARG_MODE_STEREO) begin
          dac_nxt = avg(fm_l, fm_r);
        end else if (dac_src[0] && fm_sound_mode == `ARG_MODE_DUAL) begin
          dac_nxt = fm_r;
          lvl_nxt = `ARG_LVL_CH2;
        end
      end
      default: begin
        lvl_nxt = `ARG_LVL_NICAM;
        dac_nxt = nic_m1;
        if (nicam_sound_mode == `ARG_MODE_STEREO) begin
          dac_nxt = avg(nic_l, nic_r);
        end else if (dac_src[0] && nicam_sound_mode == `ARG_MODE_DUAL) begin
          dac_nxt = nic_m2;
        end
      end
    endcase
  end

  // ==========================================================
  // sample pipeline
  assign in_ready = !s1_vld_r || fifo_rdy;
  assign accept   = ce && in_valid && in_ready;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_l_r        <= 16'h0000;
      s1_r_r        <= 16'h0000;
      s1_vld_r      <= 1'b0;
      dac_valid     <= 1'b0;
      dac_data      <= 16'h0000;
      dac_level_sel <= `ARG_LVL_CH1;
    end else if (ce) begin
      dac_valid <= accept;
      if (accept) begin
        s1_l_r        <= mx_l;
        s1_r_r        <= mx_r;
        dac_data      <= scale(dac_nxt, dac_coef(dac_gain_code));
        dac_level_sel <= lvl_nxt;
      end
      if (accept) begin
        s1_vld_r <= 1'b1;
      end else if (fifo_rdy) begin
        s1_vld_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // serial gain and output buffer
  assign gain_coef = (out_gain_r[7:5] == 3'h0) ? ser_coef(out_gain_r[4:0]) : `ARG_UNITY;
  assign g_l       = scale(s1_l_r, gain_coef);
  assign g_r       = scale(s1_r_r, gain_coef);

  arg_fifo #(
    .W  (`ARG_PAIR_W),
    .D  (`ARG_FIFO_DEPTH),
    .AW (`ARG_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .ce        (ce),
    .in_valid  (s1_vld_r),
    .in_ready  (fifo_rdy),
    .in_data   ({g_l, g_r}),
    .out_valid (ser_valid),
    .out_ready (ser_ready),
    .out_data  (ser_data)
  );
endmodule // arg_top

// >>> hw/arg_consts.vh
//
// Contract
// - manual matrix: 000 L/R, 001 L/L, 010 R/R, 011 R/L, 100 average.
// - source select 00 FM, 01 NICAM, 10 FM+NICAM M1, 11 FM+NICAM M2.
// - automatic matrix acts only for source codes 00 and 01 and matrix codes 000, 001 and 010.
// - auto mode follows sound mode: mono M/M, stereo L/R, dual A/A or B/B.
// - auto with auto-mute and channel2_mode 10 gives FM/AM mono on both.
// - serial output gain is the same on left and right.
// - gain code 0..15 is 0..+15 dB, 11110..10000 is -1..-15 dB.
// - gain, mono DAC select and preset registers reset to zero.
// - mono DAC path is always automatic; stereo gives (L+R)/2.
// - language B codes act only during dual reception, else mono.
// - FM dematrix settings never steer the mono DAC source.
// - mono DAC level comes from register 12, 13 or 15 by source.
// - DAC gain code from bits 7 and 3 adds 0, 3, 6 or 9 dB.
// - mono DAC source codes 00 FM, 01 FM B, 10 NICAM, 11 NICAM M2.
// - each preset write with a valid standard code overwrites registers 3 to 10 with standard settings.
// - preset reset value 00 is valid standard 0 but reset does not load it; registers 3 to 10 reset to zero.
// - preset bits 7:6 filter bandwidth and 5:4 ident mode, shared with register 9.
// - standard codes 0-8 and 12 valid; 9-11, 13-15 reserved.
// - output select: bit 7 auto, 6:4 matrix mode, 1:0 source, 3:2 zero.
`ifndef ARG_CONSTS_VH
`define ARG_CONSTS_VH
`define ARG_SA_DEMOD_FIRST 8'h03
`define ARG_SA_DEMOD_LAST  8'h0A
`define ARG_SA_IDENT_REG   8'h09
`define ARG_SA_OUT_SELECT  8'h16
`define ARG_SA_OUT_GAIN    8'h17
`define ARG_SA_DAC_SELECT  8'h18
`define ARG_SA_PRESET      8'hFF
`define ARG_RST_BYTE       8'h00
`define ARG_RD_NONE        8'hFF
`define ARG_SEL_MASK       8'hF3
`define ARG_MODE_MONO      2'h0
`define ARG_MODE_STEREO    2'h1
`define ARG_MODE_DUAL      2'h2
`define ARG_CH2_MUTE_MODE  2'h2
`define ARG_LVL_CH1        2'h0
`define ARG_LVL_CH2        2'h1
`define ARG_LVL_NICAM      2'h2
`define ARG_STD_LAST_A2N   4'h8
`define ARG_STD_SAT        4'hC
`define ARG_GAIN_SHIFT     12
`define ARG_UNITY          16'h1000
`define ARG_FIFO_DEPTH     16
`define ARG_FIFO_AW        4
`define ARG_PAIR_W         32
`endif

// >>> hw/arg_fifo.v
`timescale 1ns/1ns
module arg_fifo #(
  parameter W  = 32,
  parameter D  = 16,
  parameter AW = 4
) (
  clk,
  nrst,
  ce,
  in_valid,
  in_ready,
  in_data,
  out_valid,
  out_ready,
  out_data
);
  input            clk;
  input            nrst;
  input            ce;
  input            in_valid;
  output           in_ready;
  input  [W-1:0]   in_data;
  output           out_valid;
  input            out_ready;
  output [W-1:0]   out_data;

  reg    [W-1:0]   mem [0:D-1];
  reg    [AW-1:0]  wp_r;
  reg    [AW-1:0]  rp_r;
  reg    [AW:0]    cnt_r;
  wire             push;
  wire             pop;

  // ==========================================================
  // flags
  assign in_ready  = (cnt_r != D);
  assign out_valid = (cnt_r != 0);
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;
  assign out_data  = mem[rp_r];

  // ==========================================================
  // pointers and storage
  always @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // arg_fifo

// >>> verification/arg_top_assertions.sv
`timescale 1ns/1ns
// ==================================================
// port checker
module arg_top_assertions (
  input wire        clk,
  input wire        nrst,
  input wire        ce,
  input wire        reg_wr,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire [7:0]  reg_rdata,
  input wire        in_valid,
  input wire        in_ready,
  input wire        ser_valid,
  input wire        ser_ready,
  input wire [31:0] ser_data,
  input wire        dac_valid,
  input wire [63:0] demod_settings
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire wr_go  = ce && reg_wr;
  wire wr_ff  = wr_go && reg_addr == 8'hFF;
  wire std_ok = reg_wdata[3:0] <= 4'h8 || reg_wdata[3:0] == 4'hC;
  wire dm_wr  = wr_ff || (wr_go && reg_addr >= 8'h03 && reg_addr <= 8'h0A);
  dac_follow_a: assert property (ce && in_valid && in_ready |=> dac_valid)
    else $error("dac pulse missing");
  dac_cause_a: assert property (dac_valid && $past(ce) |-> $past(in_valid && in_ready))
    else $error("dac pulse without sample");
  sel_mask_a: assert property (wr_go && reg_addr == 8'h16 ##1 reg_addr == 8'h16
    |-> reg_rdata == ($past(reg_wdata) & 8'hF3)) else $error("output select bits");
  gain_store_a: assert property (wr_go && reg_addr == 8'h17 ##1 reg_addr == 8'h17
    |-> reg_rdata == $past(reg_wdata)) else $error("gain register");
  dac_store_a: assert property (wr_go && reg_addr == 8'h18 ##1 reg_addr == 8'h18
    |-> reg_rdata == $past(reg_wdata)) else $error("dac select register");
  preset_std_a: assert property (wr_ff && std_ok
    |=> demod_settings[7:0] == {$past(reg_wdata[3:0]), 4'h0}) else $error("preset load");
  preset_rsv_a: assert property (wr_ff && !std_ok
    |=> $stable(demod_settings[47:0]) && $stable(demod_settings[63:56]))
    else $error("reserved preset changed demod bytes");
  ident_copy_a: assert property (wr_ff
    |=> demod_settings[55:52] == $past(reg_wdata[7:4])) else $error("shared field");
  demod_hold_a: assert property (!dm_wr |=> $stable(demod_settings))
    else $error("demod bytes changed without write");
  ser_hold_a: assert property (ser_valid && !(ser_ready && ce)
    |=> ser_valid && $stable(ser_data)) else $error("serial pair dropped");
endmodule // arg_top_assertions

bind arg_top arg_top_assertions arg_top_assertions_i (
  .clk(clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_valid(in_valid),
  .in_ready(in_ready), .ser_valid(ser_valid), .ser_ready(ser_ready),
  .ser_data(ser_data), .dac_valid(dac_valid), .demod_settings(demod_settings));

// >>> verification/arg_host.sv
`timescale 1ns/1ns
// ==================================================
// controlling host model
module arg_host (
  input  wire       clk,
  output reg        reg_wr,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // only control bytes are written, demod bytes are left to the preset
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = (a == 8'h18) ? (d & 8'h8B) : d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // arg_host

// >>> verification/arg_top_tb.sv
`timescale 1ns/1ns
`include "arg_consts.vh"
// ==================================================
// bench
module arg_top_tb;
  reg          clk, nrst, ce, id_en, mute, in_valid, ser_ready;
  reg  [1:0]   fmm, nmm, ch2;
  reg  [15:0]  smp [0:7];
  reg  [63:0]  e;
  reg  [7:0]   v, b;
  reg  [17:0]  dv;
  reg  [31:0]  sv;
  reg  [15:0]  n;
  wire         reg_wr, in_ready, ser_valid, dac_valid;
  wire [7:0]   reg_addr, reg_wdata, reg_rdata;
  wire [31:0]  ser_data;
  wire [15:0]  dac_data;
  wire [1:0]   dac_level_sel;
  wire [63:0]  demod_settings;
  int          err_count, comparisons, i, k;
  bit          ok;
  // sel, dac select, controls, sample index for left, right, dac, level
  localparam logic [39:0] rows [16] = '{40'h00_00_20_0160, 40'h10_01_20_0060,
    40'h20_00_00_1100, 40'h30_01_40_1011, 40'h40_02_08_6672, 40'h01_03_10_2352,
    40'h11_03_00_2242, 40'h02_02_00_0442, 40'h03_00_00_0500, 40'h80_00_80_0000,
    40'h80_01_C0_0011, 40'hA0_00_C0_1100, 40'h81_02_88_2372, 40'h81_00_8E_0000,
    40'h82_00_C0_0400, 40'h90_00_20_0060};
  int          gc [6] = '{0, 1, 15, 16, 30, 31};
  logic [7:0]  ra [3] = '{8'h17, 8'h18, 8'hFF};

  arg_host arg_host_i (.clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  arg_top arg_top_i (.clk(clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fm_ident_switch_enable(id_en), .fm_sound_mode(fmm), .nicam_sound_mode(nmm),
    .auto_mute(mute), .channel2_mode(ch2), .in_valid(in_valid), .in_ready(in_ready),
    .fm_l(smp[0]), .fm_r(smp[1]), .nic_l(smp[2]), .nic_r(smp[3]), .nic_m1(smp[4]),
    .nic_m2(smp[5]), .ser_valid(ser_valid), .ser_ready(ser_ready), .ser_data(ser_data),
    .dac_valid(dac_valid), .dac_data(dac_data), .dac_level_sel(dac_level_sel),
    .demod_settings(demod_settings));

  function automatic bit near(input [15:0] x, input int db);
    real t;
    t = 2048.0 * 10.0 ** (db / 20.0);
    return $signed(x) > t - t / 50 - 2 && $signed(x) < t + t / 50 + 2;
  endfunction
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input bit good, input string msg);
    comparisons++;
    if (!good) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task put(input int lim, output bit acc);
    acc = 0;
    in_valid = 1;
    for (int j = 0; j < lim && !acc; j++) begin
      if (in_ready === 1'b1) acc = 1;
      @(negedge clk);
    end
    in_valid = 0;
  endtask
  task xfer;
    put(20, ok);
    if (!ok) begin
      chk(0, "sample refused");
      stop_test;
    end
    chk(dac_valid === 1'b1, "dac pulse");
    dv = {dac_data, dac_level_sel};
    for (int j = 0; j < 20 && ser_valid !== 1'b1; j++) @(negedge clk);
    chk(ser_valid === 1'b1, "serial pair missing");
    sv = ser_data;
    ser_ready = 1;
    @(negedge clk);
    ser_ready = 0;
  endtask

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    chk(0, "run timeout");
    stop_test;
  end
  initial begin
    nrst = 0; ce = 1; id_en = 0; mute = 0; in_valid = 0; ser_ready = 0;
    fmm = 0; nmm = 0; ch2 = 0; e = 0; err_count = 0; comparisons = 0;
    for (i = 0; i < 6; i++) smp[i] = 16'((i + 1) * 256);
    smp[6] = 16'h0180;
    smp[7] = 16'h0380;
    repeat (2) @(negedge clk);
    nrst = 1;
    for (i = 0; i < 16; i++) begin
      v = rows[i][39:32];
      b = rows[i][31:24];
      k = rows[i][23:16];
      n = rows[i][15:0];
      arg_host_i.wr(8'h16, v);
      arg_host_i.wr(8'h18, b);
      {id_en, fmm, nmm, mute, ch2} = k[7:0];
      xfer;
      chk(sv === {smp[n[15:12]], smp[n[11:8]]}, "serial pair");
      chk(dv === {smp[n[7:4]], n[1:0]}, "dac source");
    end
    $display("routing rows done");
    for (i = 0; i < 3; i++) begin
      arg_host_i.rd(ra[i], v);
      chk(v === 8'h00, "register not cleared");
    end
    chk(demod_settings === 64'h0, "demod bytes altered");
    arg_host_i.rd(8'h20, v);
    chk(v === 8'hFF, "unmapped read");
    arg_host_i.wr(8'h16, 8'hFF);
    arg_host_i.rd(8'h16, v);
    chk(v === 8'hF3, "output select bits");
    for (i = 0; i < 16; i++) begin
      b = {~i[3:0], i[3:0]};
      if (i <= 8 || i == 12) for (k = 0; k < 8; k++) e[k*8 +: 8] = {b[3:0], 1'b0, k[2:0]};
      e[55:52] = b[7:4];
      arg_host_i.wr(8'hFF, b);
      chk(demod_settings === e, "preset contents");
    end
    arg_host_i.rd(8'hFF, v);
    chk(v === b, "preset readback");
    $display("register tests done");
    arg_host_i.wr(8'h16, 8'h00);
    smp[0] = 16'h0800;
    smp[1] = 16'h0800;
    {id_en, fmm, nmm, mute, ch2} = 8'h00;
    for (i = 0; i < 4; i++) begin
      arg_host_i.wr(8'h18, {i[1], 3'h0, i[0], 3'h0});
      xfer;
      chk(near(dv[17:2], 3 * i), "dac gain");
    end
    for (i = 0; i < 6; i++) begin
      arg_host_i.wr(8'h17, 8'(gc[i]));
      xfer;
      k = gc[i] < 16 ? gc[i] : (gc[i] == 31 ? 0 : gc[i] - 31);
      chk(near(sv[31:16], k), "serial gain");
      chk(sv[31:16] === sv[15:0], "gain balance");
    end
    ce = 0;
    arg_host_i.wr(8'h17, 8'h05);
    arg_host_i.rd(8'h17, v);
    ce = 1;
    chk(v === 8'h1F, "write taken while disabled");
    $display("gain tests done");
    k = 0;
    in_valid = 1;
    for (i = 0; i < 40; i++) begin
      if (in_ready === 1'b1) k++;
      @(negedge clk);
    end
    in_valid = 0;
    chk(k == `ARG_FIFO_DEPTH + 1, "fill depth");
    ser_ready = 1;
    k = 0;
    for (i = 0; i < 40; i++) begin
      if (ser_valid === 1'b1) k++;
      @(negedge clk);
    end
    ser_ready = 0;
    chk(k == `ARG_FIFO_DEPTH + 1 && ser_valid === 1'b0 && in_ready === 1'b1, "drain");
    $display("buffer test done");
    put(20, ok);
    repeat (3) @(negedge clk);
    nrst = 0;
    @(negedge clk);
    nrst = 1;
    chk(ser_valid === 1'b0 && in_ready === 1'b1 && demod_settings === 64'h0, "second reset");
    arg_host_i.rd(8'h17, v);
    chk(v === 8'h00, "gain after reset");
    $display("reset test done");
    stop_test;
  end
endmodule // arg_top_tb
